// file: design/pcs_pkg.sv
// Purpose: Shared constants and types for the PLL clock select and trim block.
// Assumes: Byte addresses on the bus are four times the register index.
// Notes: Register layouts are packed structs; design logic takes field positions from here, though some checks use raw bit numbers.
package pcs_pkg;

  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int WB_ADR_W = 24;
  localparam int WB_DAT_W = 32;
  localparam int REG_W = 8;
  localparam logic [WB_ADR_W-1:0] IDX_OSC_TRIM = 24'h0f00a0;
  localparam logic [WB_ADR_W-1:0] IDX_SPEED_OPT = 24'h0f00f3;
  localparam logic [WB_ADR_W-1:0] IDX_PLL_STATE = 24'h0f0128;
  localparam logic [WB_ADR_W-1:0] IDX_PLL_CONTROL = 24'h0f0129;
  localparam logic [WB_ADR_W-1:0] IDX_PLL_DIVIDER = 24'h0f012a;
  localparam logic [WB_ADR_W-1:0] ADR_OSC_TRIM = IDX_OSC_TRIM << 2;
  localparam logic [WB_ADR_W-1:0] ADR_SPEED_OPT = IDX_SPEED_OPT << 2;
  localparam logic [WB_ADR_W-1:0] ADR_PLL_STATE = IDX_PLL_STATE << 2;
  localparam logic [WB_ADR_W-1:0] ADR_PLL_CONTROL = IDX_PLL_CONTROL << 2;
  localparam logic [WB_ADR_W-1:0] ADR_PLL_DIVIDER = IDX_PLL_DIVIDER << 2;

  // ------------------------------------------------------------
  // Register layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic standby_sub_clock_gate;
    logic [1:0] rsv_hi;
    logic timer_clock_source_select;
    logic [3:0] rsv_lo;
  } pcs_speed_opt_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic [5:0] code;
  } pcs_trim_t;

  typedef struct packed {
    logic [1:0] lock_wait_select;
    logic rsv5;
    logic pll_input_ratio_select;
    logic rsv3;
    logic pll_mode_select;
    logic rsv1;
    logic pll_run;
  } pcs_pll_ctl_t;

  typedef struct packed {
    logic lock;
    logic [2:0] rsv_hi;
    logic pll_mode_state;
    logic [2:0] rsv_lo;
  } pcs_pll_sts_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic [2:0] code;
  } pcs_divider_t;

  // ------------------------------------------------------------
  // Reset values, codes and timing
  // ------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam int LOCK_EXP_BASE = 7;
  localparam logic [1:0] LOCK_SEL_BAD = 2'h3;
  localparam logic [1:0] LOCK_SEL_MAX = 2'h2;
  localparam int LOCK_TARGET_NS = 40000;
  localparam logic [2:0] DIV_CODE_MAX = 3'h5;
  localparam logic [3:0] MULT_4M_OPT0 = 4'h8;
  localparam logic [3:0] MULT_4M_OPT1 = 4'h6;
  localparam logic [3:0] MULT_8M_OPT0 = 4'h4;
  localparam logic [3:0] MULT_8M_OPT1 = 4'h3;

  typedef enum logic [1:0] {
    LK_IDLE,
    LK_WAIT,
    LK_LOCKED
  } pcs_lock_state_t;

endpackage

// file: design/pcs_lock_counter.sv
// Purpose: Lockup wait counter that raises the lock flag on overflow.
// Assumes: Runs on the main clock; run_i comes from a register.
// Notes: The prohibited select code behaves as the longest wait.
`timescale 1ns/1ps
module pcs_lock_counter
  import pcs_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Control
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  // Status
  output logic locked_o
);

  pcs_lock_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] sel_eff;
  logic [CNT_W-1:0] limit;

  // A prohibited code must not shorten the wait, so it takes the longest one.
  assign sel_eff = (sel_i == LOCK_SEL_BAD) ? LOCK_SEL_MAX : sel_i;
  assign limit = CNT_W'(1) << (LOCK_EXP_BASE + int'(sel_eff));

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= LK_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        LK_IDLE: begin
          if (run_i) begin
            state_q <= LK_WAIT;
            cnt_q <= CNT_W'(1);
          end
        end
        LK_WAIT: begin
          if (!run_i) begin
            state_q <= LK_IDLE;
            cnt_q <= '0;
          end else if (cnt_q == limit - CNT_W'(1)) begin
            state_q <= LK_LOCKED;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          if (!run_i) begin
            state_q <= LK_IDLE;
            cnt_q <= '0;
          end
        end
      endcase
    end
  end

  assign locked_o = (state_q == LK_LOCKED);

endmodule

// file: design/pcs_clock_ctrl.sv
// Purpose: Clock control registers: standby gating, timer source, oscillator
//   trim, PLL run and lock, PLL mode select and PLL-derived clock divider.
// Assumes: Classic Wishbone slave, 8-bit registers in byte lane 0.
// Notes: Clock selection is given as select levels; glitch-free muxing is
//   left to the clock tree that consumes them.
`timescale 1ns/1ps
module pcs_clock_ctrl
  import pcs_pkg::*;
#(
  parameter int LOCK_CNT_W = 10
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,

  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DAT_W-1:0] wb_dat_i,
  output logic [WB_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,

  // System status
  input wire logic cpu_on_sub_clk_i,
  input wire logic standby_i,
  input wire logic [5:0] trim_default_i,
  input wire logic cfg_multiply_option_i,
  input wire logic pll_clock_stopped_i,

  // Clock controls
  output logic periph_sub_clk_en_o,
  output logic timer_clk_lowspeed_o,
  output logic [5:0] osc_trim_o,
  output logic pll_run_o,
  output logic pll_ratio_o,
  output logic clk_sel_pll_o,
  output logic [3:0] pll_mult_o,
  output logic [2:0] pll_div_code_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  pcs_speed_opt_t speed_q;
  pcs_trim_t trim_q;
  pcs_pll_ctl_t ctl_q;
  pcs_divider_t div_q;
  pcs_pll_sts_t sts;
  pcs_speed_opt_t wr_speed;
  pcs_trim_t wr_trim;
  pcs_pll_ctl_t wr_ctl;
  pcs_divider_t wr_div;
  logic trim_loaded_q;
  logic fault_q;
  logic locked;
  logic ack_q;
  logic [WB_DAT_W-1:0] dat_q;
  logic [REG_W-1:0] rd_mux;
  logic req;
  logic wr_en;
  logic periph_en_q;
  logic timer_ls_q;
  logic clk_sel_q;
  logic [3:0] mult_q;
  logic [LOCK_CNT_W-1:0] run_cyc_q;

  // ------------------------------------------------------------
  // Wishbone handshake
  // ------------------------------------------------------------
  // Ack comes one cycle after the request and drops the cycle after.
  // Writes land on the edge at which the master samples ack.
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && ack_q && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data is captured as ack rises and stands through the ack cycle.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dat_q <= '0;
    end else if (req && !ack_q) begin
      dat_q <= {{(WB_DAT_W-REG_W){1'b0}}, rd_mux};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  always_comb begin
    sts = '0;
    sts.lock = locked;
    sts.pll_mode_state = ctl_q.pll_mode_select;
    rd_mux = RST_ZERO;
    if (wb_adr_i == ADR_OSC_TRIM) begin
      rd_mux = trim_q;
    end else if (wb_adr_i == ADR_SPEED_OPT) begin
      rd_mux = speed_q;
    end else if (wb_adr_i == ADR_PLL_STATE) begin
      rd_mux = sts;
    end else if (wb_adr_i == ADR_PLL_CONTROL) begin
      rd_mux = ctl_q;
    end else if (wb_adr_i == ADR_PLL_DIVIDER) begin
      rd_mux = div_q;
    end
  end

  assign wr_speed = pcs_speed_opt_t'(wb_dat_i[REG_W-1:0]);
  assign wr_trim = pcs_trim_t'(wb_dat_i[REG_W-1:0]);
  assign wr_ctl = pcs_pll_ctl_t'(wb_dat_i[REG_W-1:0]);
  assign wr_div = pcs_divider_t'(wb_dat_i[REG_W-1:0]);

  // ------------------------------------------------------------
  // Speed and power option register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      speed_q <= pcs_speed_opt_t'(RST_ZERO);
    end else if (wr_en && wb_adr_i == ADR_SPEED_OPT) begin
      speed_q <= '0;
      speed_q.standby_sub_clock_gate <= wr_speed.standby_sub_clock_gate;
      speed_q.timer_clock_source_select <= wr_speed.timer_clock_source_select;
    end
  end

  // Only the real-time clock and interval timer keep the subsystem clock.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      periph_en_q <= 1'b1;
    end else begin
      periph_en_q <= !(speed_q.standby_sub_clock_gate && cpu_on_sub_clk_i
                       && standby_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_ls_q <= 1'b0;
    end else begin
      timer_ls_q <= speed_q.timer_clock_source_select;
    end
  end

  // ------------------------------------------------------------
  // Oscillator trim
  // ------------------------------------------------------------
  // The chip default is a strap, so it is caught on the first edge after
  // reset release rather than by the asynchronous reset itself.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trim_loaded_q <= 1'b0;
      trim_q <= pcs_trim_t'(RST_ZERO);
    end else if (!trim_loaded_q) begin
      trim_loaded_q <= 1'b1;
      trim_q.code <= trim_default_i;
    end else if (wr_en && wb_adr_i == ADR_OSC_TRIM) begin
      trim_q.code <= wr_trim.code;
    end
  end

  // ------------------------------------------------------------
  // PLL control
  // ------------------------------------------------------------
  // One process owns the whole register, so reserved positions are
  // loaded with zero on every write and never read back as one.
  // A mode select set needs the PLL running and locked, and the same
  // write must not be stopping it, otherwise the bit would flash high.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= pcs_pll_ctl_t'(RST_ZERO);
    end else if (wr_en && wb_adr_i == ADR_PLL_CONTROL) begin
      ctl_q <= '0;
      ctl_q.lock_wait_select <= wr_ctl.lock_wait_select;
      ctl_q.pll_input_ratio_select <= wr_ctl.pll_input_ratio_select;
      ctl_q.pll_run <= wr_ctl.pll_run;
      ctl_q.pll_mode_select <= wr_ctl.pll_mode_select && wr_ctl.pll_run
                               && ctl_q.pll_run && locked;
    end else if (!ctl_q.pll_run || !locked) begin
      ctl_q.pll_mode_select <= 1'b0;
    end
  end

  pcs_lock_counter #(
    .CNT_W(LOCK_CNT_W)
  ) u_lock (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .run_i(ctl_q.pll_run),
    .sel_i(ctl_q.lock_wait_select),
    .locked_o(locked)
  );

  // Once the PLL clock has been seen stopped, only a reset brings it back.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_q <= 1'b0;
    end else if (pll_clock_stopped_i) begin
      fault_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_sel_q <= 1'b0;
    end else begin
      clk_sel_q <= ctl_q.pll_mode_select && !fault_q
                   && !pll_clock_stopped_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mult_q <= MULT_4M_OPT0;
    end else begin
      case ({ctl_q.pll_input_ratio_select, cfg_multiply_option_i})
        2'h0: mult_q <= MULT_4M_OPT0;
        2'h1: mult_q <= MULT_4M_OPT1;
        2'h2: mult_q <= MULT_8M_OPT0;
        default: mult_q <= MULT_8M_OPT1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // PLL-derived clock divider
  // ------------------------------------------------------------
  // Prohibited codes are dropped so the divider never leaves its range.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= pcs_divider_t'(RST_ZERO);
    end else if (wr_en && wb_adr_i == ADR_PLL_DIVIDER
                 && wr_div.code <= DIV_CODE_MAX) begin
      div_q <= '0;
      div_q.code <= wr_div.code;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign periph_sub_clk_en_o = periph_en_q;
  assign timer_clk_lowspeed_o = timer_ls_q;
  assign osc_trim_o = trim_q.code;
  assign pll_run_o = ctl_q.pll_run;
  assign pll_ratio_o = ctl_q.pll_input_ratio_select;
  assign clk_sel_pll_o = clk_sel_q;
  assign pll_mult_o = mult_q;
  assign pll_div_code_o = div_q.code;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Counts edges with the run bit high and the lock flag still low, for the lock-time check.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_cyc_q <= '0;
    end else if (!ctl_q.pll_run) begin
      run_cyc_q <= '0;
    end else if (!locked) begin
      run_cyc_q <= run_cyc_q + LOCK_CNT_W'(1);
    end
  end

  AST_STANDBY_GATE: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    speed_q.standby_sub_clock_gate && cpu_on_sub_clk_i && standby_i
    |=> !periph_sub_clk_en_o)
    else $error("Peripheral subsystem clock not stopped in standby.");

  AST_GATE_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !speed_q.standby_sub_clock_gate |=> periph_sub_clk_en_o)
    else $error("Peripheral subsystem clock stopped with gating off.");

  AST_TIMER_SRC: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ##1 timer_clk_lowspeed_o == $past(speed_q.timer_clock_source_select))
    else $error("Timer clock source does not follow its select bit.");

  AST_TRIM_UPPER: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(wb_ack_o) && wb_adr_i == ADR_OSC_TRIM |-> wb_dat_o[7:6] == 2'h0)
    else $error("Trim register upper bits read non-zero.");

  AST_TRIM_STRAP: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(trim_loaded_q) |-> osc_trim_o == $past(trim_default_i))
    else $error("Trim code did not take the chip default after reset.");

  AST_LOCK_TIME: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(locked) && $stable(ctl_q.lock_wait_select)
    && ctl_q.lock_wait_select != LOCK_SEL_BAD
    |-> run_cyc_q == (LOCK_CNT_W'(1) << (LOCK_EXP_BASE
                      + int'(ctl_q.lock_wait_select))))
    else $error("Lock flag rose after the wrong number of cycles.");

  AST_RUN_STOP: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !ctl_q.pll_run |=> !locked)
    else $error("Lock flag stayed set with the PLL stopped.");

  AST_SEL_GUARD: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(ctl_q.pll_mode_select) |-> $past(ctl_q.pll_run) && $past(locked))
    else $error("Mode select set while PLL not running and locked.");

  AST_SEL_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (!ctl_q.pll_run || !locked) |=> !ctl_q.pll_mode_select)
    else $error("Mode select not cleared with run or lock low.");

  AST_FALLBACK: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    pll_clock_stopped_i |=> (!clk_sel_pll_o && fault_q) [*2])
    else $error("PLL clock still selected after it stopped.");

  AST_MODE_MUX: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    ctl_q.pll_mode_select && !fault_q && !pll_clock_stopped_i
    |=> clk_sel_pll_o)
    else $error("PLL clock not selected with mode select set.");

  AST_DIV_RANGE: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    pll_div_code_o <= DIV_CODE_MAX)
    else $error("Divider holds a prohibited code.");

  AST_CTL_RSV: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(wb_ack_o) && wb_adr_i == ADR_PLL_CONTROL
    |-> !wb_dat_o[5] && !wb_dat_o[3] && !wb_dat_o[1])
    else $error("Control register reserved bits read non-zero.");

endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the clock control block over classic Wishbone.
// Assumes: Registers answer in lane 0; ack comes a fixed cycle after a request.
// Notes: Lock timing is bracketed by one early and one late status read.
`timescale 1ns/1ps
module testbench;
  import pcs_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys_i, resetn_i, cyc, stb, we, ack;
  logic [WB_ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [WB_DAT_W-1:0] wdat, rdat;
  logic cpu_sub, standby, cfg_opt, pll_stop;
  logic [5:0] trim_def, osc_trim;
  logic periph_en, timer_ls, pll_run, pll_ratio, clk_sel;
  logic [3:0] mult;
  logic [2:0] div_code;
  logic [7:0] d, ctl;
  int num_errors, tests_run, n;

  pcs_clock_ctrl #(.LOCK_CNT_W(10)) u_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpu_on_sub_clk_i(cpu_sub), .standby_i(standby),
    .trim_default_i(trim_def), .cfg_multiply_option_i(cfg_opt),
    .pll_clock_stopped_i(pll_stop), .periph_sub_clk_en_o(periph_en),
    .timer_clk_lowspeed_o(timer_ls), .osc_trim_o(osc_trim), .pll_run_o(pll_run),
    .pll_ratio_o(pll_ratio), .clk_sel_pll_o(clk_sel), .pll_mult_o(mult),
    .pll_div_code_o(div_code));

  always #2.5 clk_sys_i = ~clk_sys_i;

  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask

  // The request stands untouched until the edge that samples ack high.
  task automatic wb_access(input logic w, input logic [WB_ADR_W-1:0] a,
                           input logic [7:0] v, input logic [3:0] s);
    int k;
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h000000, v};
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    d = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      num_errors++;
      $display("BAD %0t no bus acknowledge", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [WB_ADR_W-1:0] a, input logic [7:0] v);
    wb_access(1'b1, a, v, 4'h1);
  endtask

  task automatic rd_chk(input logic [WB_ADR_W-1:0] a, input logic [7:0] exp);
    wb_access(1'b0, a, 8'h00, 4'h1);
    chk_reg(d, exp);
  endtask

  // Registered outputs lag their cause by one clock.
  task automatic settle();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    resetn_i = 1'b0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    {cpu_sub, standby, cfg_opt, pll_stop} = '0;
    trim_def = 6'h2a;
    num_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys_i);
    #1;
    chk_pin({7'h00, periph_en}, 8'h01);
    chk_pin({4'h0, mult}, {4'h0, MULT_4M_OPT0});
    chk_pin({7'h00, clk_sel}, 8'h00);
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    settle();
    chk_pin({2'h0, osc_trim}, 8'h2a);
    rd_chk(ADR_OSC_TRIM, 8'h2a);
    rd_chk(ADR_SPEED_OPT, RST_ZERO);
    rd_chk(ADR_PLL_STATE, RST_ZERO);
    rd_chk(ADR_PLL_CONTROL, RST_ZERO);
    rd_chk(ADR_PLL_DIVIDER, RST_ZERO);
    wr(ADR_OSC_TRIM, 8'hff);
    rd_chk(ADR_OSC_TRIM, 8'h3f);
    wb_access(1'b1, ADR_OSC_TRIM, 8'h05, 4'h0);
    rd_chk(ADR_OSC_TRIM, 8'h3f);
    settle();
    chk_pin({2'h0, osc_trim}, 8'h3f);
    wr(24'h000100, 8'hff);
    rd_chk(24'h000100, 8'h00);
    // Standby gating only bites while the CPU runs from the subsystem clock.
    @(posedge clk_sys_i);
    cpu_sub <= 1'b1;
    standby <= 1'b1;
    settle();
    chk_pin({7'h00, periph_en}, 8'h01);
    wr(ADR_SPEED_OPT, 8'h80);
    settle();
    chk_pin({7'h00, periph_en}, 8'h00);
    @(posedge clk_sys_i);
    standby <= 1'b0;
    settle();
    chk_pin({7'h00, periph_en}, 8'h01);
    wr(ADR_SPEED_OPT, 8'h10);
    rd_chk(ADR_SPEED_OPT, 8'h10);
    standby <= 1'b1;
    settle();
    chk_pin({7'h00, timer_ls}, 8'h01);
    chk_pin({7'h00, periph_en}, 8'h01);
    wr(ADR_SPEED_OPT, 8'h00);
    settle();
    chk_pin({7'h00, timer_ls}, 8'h00);
    wr(ADR_PLL_CONTROL, 8'h2a);
    rd_chk(ADR_PLL_CONTROL, 8'h00);
    wr(ADR_PLL_CONTROL, 8'h05);
    rd_chk(ADR_PLL_CONTROL, 8'h01);
    rd_chk(ADR_PLL_STATE, 8'h00);
    wr(ADR_PLL_CONTROL, 8'h00);
    // Ratio and option change only while the PLL is stopped.
    for (int i = 0; i < 5; i++) begin
      n = 1 << (LOCK_EXP_BASE + (i % 3));
      ctl = {2'(i % 3), 1'b0, i[0], 4'h1};
      @(posedge clk_sys_i);
      cfg_opt <= i[1];
      wr(ADR_PLL_CONTROL, ctl);
      repeat (n - 12) @(posedge clk_sys_i);
      rd_chk(ADR_PLL_STATE, 8'h00);
      repeat (14) @(posedge clk_sys_i);
      rd_chk(ADR_PLL_STATE, 8'h80);
      wr(ADR_PLL_CONTROL, ctl | 8'h04);
      rd_chk(ADR_PLL_CONTROL, ctl | 8'h04);
      rd_chk(ADR_PLL_STATE, 8'h88);
      settle();
      chk_pin({7'h00, clk_sel}, 8'h01);
      chk_pin({6'h00, pll_run, pll_ratio}, {6'h00, 1'b1, i[0]});
      chk_pin({4'h0, mult}, {4'h0, i[1] ? (i[0] ? MULT_8M_OPT1 : MULT_4M_OPT1)
                                          : (i[0] ? MULT_8M_OPT0 : MULT_4M_OPT0)});
      if (i == 4) begin
        @(posedge clk_sys_i);
        pll_stop <= 1'b1;
        @(posedge clk_sys_i);
        pll_stop <= 1'b0;
        settle();
        chk_pin({7'h00, clk_sel}, 8'h00);
        rd_chk(ADR_PLL_STATE, 8'h88);
        rd_chk(ADR_PLL_CONTROL, ctl | 8'h04);
      end
      wr(ADR_PLL_CONTROL, ctl & 8'hfe);
      rd_chk(ADR_PLL_CONTROL, ctl & 8'hf0);
      rd_chk(ADR_PLL_STATE, 8'h00);
      settle();
      chk_pin({6'h00, pll_run, clk_sel}, 8'h00);
    end
    // Upper divider bits are always written as zero.
    for (int c = 0; c < 6; c++) begin
      wr(ADR_PLL_DIVIDER, 8'(c));
      rd_chk(ADR_PLL_DIVIDER, 8'(c));
      settle();
      chk_pin({5'h00, div_code}, 8'(c));
    end
    wr(ADR_PLL_DIVIDER, 8'h06);
    rd_chk(ADR_PLL_DIVIDER, {5'h00, DIV_CODE_MAX});
    wr(ADR_PLL_DIVIDER, 8'h07);
    rd_chk(ADR_PLL_DIVIDER, {5'h00, DIV_CODE_MAX});
    tally_and_finish();
  end

endmodule
